// ---- rtl/pao_regs.svh ----
// Register offsets, field positions and codes of the phase accumulator oscillator.
`ifndef PAO_REGS_SVH
`define PAO_REGS_SVH

`define PAO_OFF_CTRL     8'h00
`define PAO_OFF_CLK      8'h04
`define PAO_OFF_ACCL     8'h08
`define PAO_OFF_ACCH     8'h0C
`define PAO_OFF_ACCU     8'h10
`define PAO_OFF_INCL     8'h14
`define PAO_OFF_INCH     8'h18
`define PAO_OFF_INCU     8'h1C
`define PAO_OFF_STAT     8'h20
`define PAO_OFF_ROUTE    8'h24

`define PAO_CTRL_EN      7
`define PAO_CTRL_OUT     5
`define PAO_CTRL_POL     4
`define PAO_CTRL_PFM     0
`define PAO_CLK_PWS      7:5
`define PAO_CLK_CKS      2:0
`define PAO_STAT_FLAG    0
`define PAO_ROUTE_PIN    0

`define PAO_BYTE_L       7:0
`define PAO_BYTE_H       15:8
`define PAO_BYTE_U       19:16
`define PAO_NIB          3:0
`define PAO_CARRY_BIT    20
`define PAO_RST_BYTE     8'h00
`define PAO_RST_WORD     20'h00000
`define PAO_RST_DATA     32'h00000000
`define PAO_RD_PAD       24'h000000

`define PAO_CKS_SYS      3'h0
`define PAO_CKS_HF       3'h1
`define PAO_CKS_LC1      3'h2
`define PAO_CKS_LC2      3'h3
`define PAO_CKS_LC3      3'h4
`define PAO_CKS_LC4      3'h5
`define PAO_CKS_RSV      3'h6

`endif

// ---- rtl/pao_pkg.sv ----
// Types shared by the phase accumulator oscillator design.
package pao_pkg;
  typedef logic [19:0] pao_word_type;
  typedef logic [7:0]  pao_byte_type;
  typedef logic [7:0]  pao_addr_type;
  typedef logic [31:0] pao_data_type;
  typedef enum logic [1:0] {
    PAO_LD_IDLE  = 2'h0,
    PAO_LD_ARMED = 2'h1,
    PAO_LD_FIRST = 2'h3
  } pao_load_state_type;
endpackage

// ---- rtl/pao_clk_sel.sv ----
// Input clock source selector and rising edge detector of the oscillator.
`timescale 1ns/100ps
`include "pao_regs.svh"

module pao_clk_sel (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Source selection.
  input  wire logic [2:0] clock_source_select,
  input  wire logic       sys_osc,
  input  wire logic       internal_hf_osc,
  input  wire logic       logic_cell1_output,
  input  wire logic       logic_cell2_output,
  input  wire logic       logic_cell3_output,
  input  wire logic       logic_cell4_output,
  // One-cycle enable on each rising edge of the selected source.
  output logic            tick
);
  import pao_pkg::*;

  logic level_ff;
  logic nxt_level;
  logic prev_ff;
  logic nxt_prev;

  // Reserved codes select a constant low, so they never produce a tick.
  always_comb begin
    case (clock_source_select)  // [RULE_09]
      `PAO_CKS_SYS: nxt_level = sys_osc;  // [RULE_17]
      `PAO_CKS_HF:  nxt_level = internal_hf_osc;
      `PAO_CKS_LC1: nxt_level = logic_cell1_output;
      `PAO_CKS_LC2: nxt_level = logic_cell2_output;
      `PAO_CKS_LC3: nxt_level = logic_cell3_output;
      `PAO_CKS_LC4: nxt_level = logic_cell4_output;
      default:      nxt_level = 1'b0;
    endcase
    nxt_prev = level_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      prev_ff  <= nxt_prev;
    end
  end

  // Switching the source may produce one extra tick; software should do it while disabled.
  assign tick = level_ff && !prev_ff;

  property p_rsv_quiet;
    @(posedge clk) disable iff (rst)
    (clock_source_select >= `PAO_CKS_RSV) [*3] |-> !tick;
  endproperty
  a_rsv_quiet: assert property (p_rsv_quiet) else $error("Reserved source gave a tick.");  // [RULE_17]
endmodule

// ---- rtl/pao_osc.sv ----
// Phase accumulator oscillator: APB registers, accumulator, shaping and output stage.
//
// Summary of operation
// RULE_01 - A 20-bit accumulator is read and written as low, high and upper bytes.
// RULE_02 - Each selected clock edge, accumulator becomes accumulator plus buffered increment.
// RULE_03 - The carry of that addition is the raw overflow pulse.
// RULE_04 - The 20-bit increment sits in low, high and upper read/write bytes.
// RULE_05 - Software writes upper and high increment bytes before the low byte.
// RULE_06 - Enabled: a low byte write loads the buffer on the second following edge.
// RULE_07 - The increment is double buffered; the buffer is hidden from software.
// RULE_08 - Disabled: the buffer loads straight after any increment write.
// RULE_09 - A three-bit field picks one of six input clock sources.
// RULE_10 - Fixed duty mode toggles the output on every overflow.
// RULE_11 - Pulse mode bit clear selects fixed duty, set selects pulse frequency.
// RULE_12 - Pulse mode drives output active after overflow for the chosen periods.
// RULE_13 - The polarity bit sets the active and inactive output levels.
// RULE_14 - Software keeps the pulse width below the overflow period.
// RULE_15 - Every accumulator overflow raises an interrupt event.
// RULE_16 - The shaped output goes to other peripherals and optionally a pin.
// RULE_17 - Source codes: 0 system, 1 fast internal, 2-5 logic cells, 6-7 reserved.
// RULE_18 - Pulse width is two to the width field power input periods.
// RULE_19 - Reset clears every register of the block to zero.
// RULE_20 - Software clears the overflow flag; hardware only sets it.
// RULE_21 - Disabled: accumulation stops and the output holds its inactive level.
// RULE_22 - Polarity bit set inverts output; a status bit shows the output value.
`timescale 1ns/100ps
`include "pao_regs.svh"

module pao_osc (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire pao_pkg::pao_addr_type paddr,
  input  wire pao_pkg::pao_data_type pwdata,
  output pao_pkg::pao_data_type      prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Input clock sources.
  input  wire logic                  sys_osc,
  input  wire logic                  internal_hf_osc,
  input  wire logic                  logic_cell1_output,
  input  wire logic                  logic_cell2_output,
  input  wire logic                  logic_cell3_output,
  input  wire logic                  logic_cell4_output,
  // Oscillator outputs.
  output logic                       nco_out,
  output logic                       pin_out,
  output logic                       pin_out_en,
  output logic                       overflow_event,
  output logic                       overflow_irq_flag
);
  import pao_pkg::*;

  logic               en_ff, nxt_en;
  logic               pol_ff, nxt_pol;
  logic               pfm_ff, nxt_pfm;
  logic               route_ff, nxt_route;
  logic [2:0]         pws_ff, nxt_pws;
  logic [2:0]         cks_ff, nxt_cks;
  pao_word_type       inc_ff, nxt_inc;
  pao_word_type       acc_ff, nxt_acc;
  pao_word_type       incbuf_ff, nxt_incbuf;
  pao_load_state_type ld_ff, nxt_ld;
  logic               flag_ff, nxt_flag;
  logic               event_ff, nxt_event;
  logic               q_ff, nxt_q;
  logic               pulse_ff, nxt_pulse;
  logic [6:0]         wcnt_ff, nxt_wcnt;
  logic               out_ff, nxt_out;
  pao_data_type       prdata_ff, nxt_prdata;
  logic               wr_acc;
  logic               rd_setup;
  logic               acc_wr;
  logic               incl_wr;
  logic               sync_tick;
  logic               carry;
  logic [20:0]        sum;

  function automatic logic pao_mapped(input pao_addr_type a);
    case (a)
      `PAO_OFF_CTRL, `PAO_OFF_CLK, `PAO_OFF_ACCL, `PAO_OFF_ACCH, `PAO_OFF_ACCU,
      `PAO_OFF_INCL, `PAO_OFF_INCH, `PAO_OFF_INCU, `PAO_OFF_STAT,
      `PAO_OFF_ROUTE: pao_mapped = 1'b1;
      default:        pao_mapped = 1'b0;
    endcase
  endfunction

  // Active time less one, in input clock periods.
  function automatic logic [6:0] pao_width_m1(input logic [2:0] sel);
    logic [7:0] len;
    len = 8'h01 << sel;
    pao_width_m1 = 7'(len - 8'h01);
  endfunction

  pao_clk_sel u_clk_sel (
    .clk                 (clk),
    .rst                 (rst),
    .clock_source_select (cks_ff),
    .sys_osc             (sys_osc),
    .internal_hf_osc     (internal_hf_osc),
    .logic_cell1_output  (logic_cell1_output),
    .logic_cell2_output  (logic_cell2_output),
    .logic_cell3_output  (logic_cell3_output),
    .logic_cell4_output  (logic_cell4_output),
    .tick                (sync_tick)
  );

  // Zero-wait slave: read data is captured in the setup cycle.
  assign wr_acc   = psel && penable && pwrite && pao_mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign acc_wr   = wr_acc && (paddr == `PAO_OFF_ACCL || paddr == `PAO_OFF_ACCH ||
                               paddr == `PAO_OFF_ACCU);
  assign incl_wr  = wr_acc && (paddr == `PAO_OFF_INCL);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !pao_mapped(paddr);
  assign prdata   = prdata_ff;

  always_comb begin
    pao_byte_type b;
    b = `PAO_RST_BYTE;
    case (paddr)
      `PAO_OFF_CTRL: begin
        b[`PAO_CTRL_EN]  = en_ff;
        b[`PAO_CTRL_OUT] = out_ff;  // [RULE_22]
        b[`PAO_CTRL_POL] = pol_ff;
        b[`PAO_CTRL_PFM] = pfm_ff;
      end
      `PAO_OFF_CLK: begin
        b[`PAO_CLK_PWS] = pws_ff;
        b[`PAO_CLK_CKS] = cks_ff;
      end
      `PAO_OFF_ACCL:  b = acc_ff[`PAO_BYTE_L];  // [RULE_01]
      `PAO_OFF_ACCH:  b = acc_ff[`PAO_BYTE_H];
      `PAO_OFF_ACCU:  b[`PAO_NIB] = acc_ff[`PAO_BYTE_U];
      `PAO_OFF_INCL:  b = inc_ff[`PAO_BYTE_L];  // [RULE_04] [RULE_07]
      `PAO_OFF_INCH:  b = inc_ff[`PAO_BYTE_H];
      `PAO_OFF_INCU:  b[`PAO_NIB] = inc_ff[`PAO_BYTE_U];
      `PAO_OFF_STAT:  b[`PAO_STAT_FLAG] = flag_ff;
      `PAO_OFF_ROUTE: b[`PAO_ROUTE_PIN] = route_ff;
      default:        b = `PAO_RST_BYTE;
    endcase
    nxt_prdata = rd_setup ? {`PAO_RD_PAD, b} : prdata_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_ff <= `PAO_RST_DATA;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Configuration and increment registers.
  always_comb begin
    nxt_en    = en_ff;
    nxt_pol   = pol_ff;
    nxt_pfm   = pfm_ff;
    nxt_route = route_ff;
    nxt_pws   = pws_ff;
    nxt_cks   = cks_ff;
    nxt_inc   = inc_ff;
    if (wr_acc) begin
      case (paddr)
        `PAO_OFF_CTRL: begin
          nxt_en  = pwdata[`PAO_CTRL_EN];
          nxt_pol = pwdata[`PAO_CTRL_POL];
          nxt_pfm = pwdata[`PAO_CTRL_PFM];  // [RULE_11]
        end
        `PAO_OFF_CLK: begin
          nxt_pws = pwdata[`PAO_CLK_PWS];
          nxt_cks = pwdata[`PAO_CLK_CKS];  // [RULE_09]
        end
        `PAO_OFF_INCL:  nxt_inc[`PAO_BYTE_L] = pwdata[`PAO_BYTE_L];  // [RULE_04]
        `PAO_OFF_INCH:  nxt_inc[`PAO_BYTE_H] = pwdata[`PAO_BYTE_L];
        `PAO_OFF_INCU:  nxt_inc[`PAO_BYTE_U] = pwdata[`PAO_NIB];
        `PAO_OFF_ROUTE: nxt_route = pwdata[`PAO_ROUTE_PIN];
        default:        nxt_route = route_ff;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin  // [RULE_19]
      en_ff    <= 1'b0;
      pol_ff   <= 1'b0;
      pfm_ff   <= 1'b0;
      route_ff <= 1'b0;
      pws_ff   <= 3'h0;
      cks_ff   <= 3'h0;
      inc_ff   <= `PAO_RST_WORD;
    end else begin
      en_ff    <= nxt_en;
      pol_ff   <= nxt_pol;
      pfm_ff   <= nxt_pfm;
      route_ff <= nxt_route;
      pws_ff   <= nxt_pws;
      cks_ff   <= nxt_cks;
      inc_ff   <= nxt_inc;
    end
  end

  // Accumulator, increment buffer and overflow flag.
  assign sum   = {1'b0, acc_ff} + {1'b0, incbuf_ff};  // [RULE_02]
  assign carry = en_ff && sync_tick && sum[`PAO_CARRY_BIT];  // [RULE_03]

  always_comb begin
    nxt_acc    = acc_ff;
    nxt_incbuf = incbuf_ff;
    nxt_ld     = ld_ff;
    nxt_flag   = flag_ff;
    nxt_event  = carry;  // [RULE_15]
    if (en_ff && sync_tick) begin
      nxt_acc = pao_word_type'(sum);  // [RULE_02]
    end
    // A software write wins over an addition in the same cycle for the byte it writes; other bytes take the sum.
    if (acc_wr) begin  // [RULE_01]
      case (paddr)
        `PAO_OFF_ACCL: nxt_acc[`PAO_BYTE_L] = pwdata[`PAO_BYTE_L];
        `PAO_OFF_ACCH: nxt_acc[`PAO_BYTE_H] = pwdata[`PAO_BYTE_L];
        default:       nxt_acc[`PAO_BYTE_U] = pwdata[`PAO_NIB];
      endcase
    end
    if (!en_ff) begin
      nxt_incbuf = inc_ff;  // [RULE_08]
      nxt_ld     = PAO_LD_IDLE;
    end else begin
      case (ld_ff)  // [RULE_06]
        PAO_LD_IDLE:  nxt_ld = PAO_LD_IDLE;
        PAO_LD_ARMED: nxt_ld = sync_tick ? PAO_LD_FIRST : PAO_LD_ARMED;
        PAO_LD_FIRST: begin
          if (sync_tick) begin
            nxt_incbuf = inc_ff;  // [RULE_07]
            nxt_ld     = PAO_LD_IDLE;
          end
        end
        default:      nxt_ld = PAO_LD_IDLE;
      endcase
      if (incl_wr) begin
        nxt_ld = PAO_LD_ARMED;
      end
    end
    if (wr_acc && paddr == `PAO_OFF_STAT && !pwdata[`PAO_STAT_FLAG]) begin
      nxt_flag = 1'b0;
    end
    if (carry) begin
      nxt_flag = 1'b1;  // [RULE_15] [RULE_20]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff    <= `PAO_RST_WORD;
      incbuf_ff <= `PAO_RST_WORD;
      ld_ff     <= PAO_LD_IDLE;
      flag_ff   <= 1'b0;
      event_ff  <= 1'b0;
    end else begin
      acc_ff    <= nxt_acc;
      incbuf_ff <= nxt_incbuf;
      ld_ff     <= nxt_ld;
      flag_ff   <= nxt_flag;
      event_ff  <= nxt_event;
    end
  end

  // Output shaping and polarity; a too-wide pulse simply restarts on the next overflow.
  always_comb begin
    nxt_q     = q_ff;
    nxt_pulse = pulse_ff;
    nxt_wcnt  = wcnt_ff;
    if (!en_ff) begin
      nxt_q     = 1'b0;
      nxt_pulse = 1'b0;
      nxt_wcnt  = 7'h00;
    end else if (carry) begin
      nxt_q     = pfm_ff ? q_ff : !q_ff;  // [RULE_10]
      nxt_pulse = pfm_ff;  // [RULE_12]
      nxt_wcnt  = pao_width_m1(pws_ff);  // [RULE_18] [RULE_14]
    end else if (sync_tick && pulse_ff) begin
      if (wcnt_ff == 7'h00) begin
        nxt_pulse = 1'b0;
      end else begin
        nxt_wcnt = wcnt_ff - 7'h01;
      end
    end
    nxt_out = ((pfm_ff ? pulse_ff : q_ff) && en_ff) ^ pol_ff;  // [RULE_11] [RULE_13] [RULE_21]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_ff     <= 1'b0;
      pulse_ff <= 1'b0;
      wcnt_ff  <= 7'h00;
      out_ff   <= 1'b0;
    end else begin
      q_ff     <= nxt_q;
      pulse_ff <= nxt_pulse;
      wcnt_ff  <= nxt_wcnt;
      out_ff   <= nxt_out;
    end
  end

  assign nco_out           = out_ff;  // [RULE_16]
  assign pin_out           = out_ff;
  assign pin_out_en        = route_ff;
  assign overflow_event    = event_ff;
  assign overflow_irq_flag = flag_ff;

  property p_acc_add;
    @(posedge clk) disable iff (rst)
    (en_ff && sync_tick && !acc_wr) |=> (acc_ff == 20'($past(acc_ff) + $past(incbuf_ff)));
  endproperty
  a_acc_add: assert property (p_acc_add) else $error("Accumulator sum wrong.");  // [RULE_02]

  property p_carry;
    @(posedge clk) disable iff (rst)
    (en_ff && sync_tick && !acc_wr) |=> (overflow_event == (acc_ff < $past(acc_ff)));
  endproperty
  a_carry: assert property (p_carry) else $error("Overflow pulse mismatch.");  // [RULE_03]

  property p_late_load;
    @(posedge clk) disable iff (rst)
    (incl_wr && en_ff && nxt_en) |=> $stable(incbuf_ff);
  endproperty
  a_late_load: assert property (p_late_load) else $error("Buffer loaded too early.");  // [RULE_06]

  property p_second_edge;
    @(posedge clk) disable iff (rst)
    (ld_ff == PAO_LD_FIRST && sync_tick && en_ff) |=> (incbuf_ff == $past(inc_ff));
  endproperty
  a_second_edge: assert property (p_second_edge) else $error("Buffer not loaded.");  // [RULE_06]

  property p_off_load;
    @(posedge clk) disable iff (rst)
    !en_ff |=> (incbuf_ff == $past(inc_ff));
  endproperty
  a_off_load: assert property (p_off_load) else $error("Disabled buffer stale.");  // [RULE_08]

  property p_toggle;
    @(posedge clk) disable iff (rst)
    (carry && !pfm_ff) |=> (q_ff != $past(q_ff)) ##1 (out_ff == (q_ff ^ pol_ff));
  endproperty
  a_toggle: assert property (p_toggle) else $error("Fixed duty did not toggle.");  // [RULE_10]

  property p_pulse;
    @(posedge clk) disable iff (rst)
    (carry && pfm_ff) |=> (pulse_ff && wcnt_ff == pao_width_m1($past(pws_ff)));
  endproperty
  a_pulse: assert property (p_pulse) else $error("Pulse width not loaded.");  // [RULE_18]

  // The output flop follows the polarity seen one cycle earlier, so compare with that value.
  property p_idle_out;
    @(posedge clk) disable iff (rst)
    !en_ff |=> (out_ff == $past(pol_ff));
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("Output not inactive.");  // [RULE_21]

  property p_flag;
    @(posedge clk) disable iff (rst)
    carry |=> (overflow_irq_flag && overflow_event);
  endproperty
  a_flag: assert property (p_flag) else $error("Overflow flag not set.");  // [RULE_15]
endmodule

// ---- test/tb.sv ----
// Self-checking testbench of the phase accumulator oscillator.
`timescale 1ns/100ps
`include "pao_regs.svh"

module tb;
  import pao_pkg::*;

  logic         clk;
  logic         rst;
  logic         psel;
  logic         penable;
  logic         pwrite;
  pao_addr_type paddr;
  pao_data_type pwdata;
  pao_data_type prdata;
  logic         pready;
  logic         pslverr;
  logic [5:0]   srcs;
  logic         nco_out;
  logic         pin_out;
  logic         pin_out_en;
  logic         overflow_event;
  logic         overflow_irq_flag;
  logic [32:0]  exp_q[$];
  logic [32:0]  e;
  logic [15:0]  seed;
  int           n_mismatch;
  int           checked;
  int           n_ev;

  localparam pao_addr_type OFFS [8] = '{`PAO_OFF_CLK, `PAO_OFF_ACCL, `PAO_OFF_ACCH,
    `PAO_OFF_ACCU, `PAO_OFF_INCL, `PAO_OFF_INCH, `PAO_OFF_INCU, `PAO_OFF_ROUTE};
  localparam pao_byte_type MSK [8] = '{8'hE7, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'h01};

  pao_osc pao_osc_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_osc(srcs[0]), .internal_hf_osc(srcs[1]), .logic_cell1_output(srcs[2]),
    .logic_cell2_output(srcs[3]), .logic_cell3_output(srcs[4]),
    .logic_cell4_output(srcs[5]), .nco_out(nco_out), .pin_out(pin_out),
    .pin_out_en(pin_out_en), .overflow_event(overflow_event),
    .overflow_irq_flag(overflow_irq_flag)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  function automatic pao_word_type r20();
    logic [15:0] a;
    a = rnd();
    return {a[3:0], rnd()};
  endfunction

  // Read results are compared when the access phase completes.
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (pwrite)
        chk({pslverr, 32'h0}, {e[32], 32'h0});
      else
        chk({pslverr, prdata}, e);
    end
  end

  always @(posedge clk) begin
    if (rst)
      n_ev <= 0;
    else if (overflow_event === 1'b1)
      n_ev <= n_ev + 1;
  end

  task automatic apb(input logic w, input pao_addr_type a, input pao_data_type d,
                     input logic [32:0] x);
    int n;
    exp_q.push_back(x);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input pao_addr_type a, input pao_byte_type v);
    apb(1'b1, a, {24'h0, v}, 33'h0);
  endtask

  task automatic rd(input pao_addr_type a, input pao_byte_type v);
    apb(1'b0, a, 32'h0, {25'h0, v});
  endtask

  // Upper and high bytes go first so a low byte write sees a complete value.
  task automatic wr20(input pao_addr_type b, input pao_word_type v);
    wr(b + 8'h08, {4'h0, v[19:16]});
    wr(b + 8'h04, v[15:8]);
    wr(b, v[7:0]);
  endtask

  task automatic rd20(input pao_addr_type b, input pao_word_type v);
    rd(b, v[7:0]);
    rd(b + 8'h04, v[15:8]);
    rd(b + 8'h08, {4'h0, v[19:16]});
  endtask

  // Reserved codes pulse every source, since none of them may be counted.
  task automatic pulses(input int code, input int n, input int w);
    repeat (n) begin
      @(posedge clk);
      srcs <= (code < 6) ? 6'h01 << code : 6'h3F;
      repeat (w) @(posedge clk);
      srcs <= 6'h00;
      repeat (w - 1) @(posedge clk);
    end
  endtask

  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end

  initial begin
    int           i;
    int           k;
    int           cnt;
    int           sum;
    logic         pol;
    pao_byte_type v;
    pao_word_type inc;
    pao_word_type acc0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    srcs = 6'h00;
    seed = 16'hB6A7;
    n_mismatch = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      v = pao_byte_type'(rnd());
      wr(OFFS[i], v);
      rd(OFFS[i], v & MSK[i]);
    end
    v = pao_byte_type'(rnd()) & 8'h11;
    wr(`PAO_OFF_CTRL, v);
    rd(`PAO_OFF_CTRL, v | {2'h0, v[4], 5'h0});
    wr(`PAO_OFF_CTRL, 8'h00);
    apb(1'b1, 8'h28, 32'hFF, {1'b1, 32'h0});
    apb(1'b0, 8'h28, 32'h0, {1'b1, 32'h0});
    for (k = 0; k < 8; k++) begin
      inc = r20();
      acc0 = r20();
      wr(`PAO_OFF_STAT, 8'h00);
      wr(`PAO_OFF_CLK, 8'(k));
      wr20(`PAO_OFF_INCL, inc);
      wr20(`PAO_OFF_ACCL, acc0);
      cnt = n_ev;
      wr(`PAO_OFF_CTRL, 8'h80);
      pulses(k, 5, 2);
      repeat (4) @(posedge clk);
      wr(`PAO_OFF_CTRL, 8'h00);
      sum = int'(acc0) + ((k < 6) ? 5 * int'(inc) : 0);
      rd20(`PAO_OFF_ACCL, pao_word_type'(sum));
      chk(33'(n_ev - cnt), 33'(sum >> 20));
      rd(`PAO_OFF_STAT, {7'h0, sum > 32'h000FFFFF});
    end
    wr20(`PAO_OFF_INCL, 20'h12345);
    wr20(`PAO_OFF_ACCL, 20'h00000);
    wr(`PAO_OFF_CLK, 8'h00);
    wr(`PAO_OFF_CTRL, 8'h80);
    wr20(`PAO_OFF_INCL, 20'h0ABCD);
    pulses(0, 1, 2);
    repeat (4) @(posedge clk);
    rd20(`PAO_OFF_ACCL, 20'h12345);
    rd20(`PAO_OFF_INCL, 20'h0ABCD);
    pulses(0, 1, 2);
    repeat (4) @(posedge clk);
    wr20(`PAO_OFF_ACCL, 20'h00000);
    pulses(0, 2, 2);
    repeat (4) @(posedge clk);
    wr(`PAO_OFF_CTRL, 8'h00);
    rd20(`PAO_OFF_ACCL, 20'h1579A);
    for (i = 0; i < 2; i++) begin
      pol = i[0];
      wr(`PAO_OFF_CTRL, {3'h0, pol, 4'h0});
      wr(`PAO_OFF_ROUTE, 8'h01);
      wr20(`PAO_OFF_INCL, 20'h80000);
      wr20(`PAO_OFF_ACCL, 20'h00000);
      #1;
      chk({32'h0, nco_out}, {32'h0, pol});
      chk({32'h0, pin_out_en}, 33'h1);
      wr(`PAO_OFF_CTRL, {1'b1, 2'h0, pol, 4'h0});
      for (k = 1; k < 4; k++) begin
        pulses(0, 2, 2);
        repeat (4) @(posedge clk);
        #1;
        chk({31'h0, nco_out, pin_out}, {31'h0, {2{pol ^ k[0]}}});
        rd(`PAO_OFF_CTRL, {2'h2, pol ^ k[0], pol, 4'h0});
      end
    end
    wr(`PAO_OFF_ROUTE, 8'h00);
    for (i = 0; i < 8; i++) begin
      pol = i[0];
      wr(`PAO_OFF_CTRL, {3'h0, pol, 4'h0});
      wr(`PAO_OFF_CLK, {i[2:0], 5'h00});
      wr20(`PAO_OFF_INCL, 20'h01000);
      wr20(`PAO_OFF_ACCL, 20'hFF000);
      wr(`PAO_OFF_CTRL, {3'h4, pol, 4'h1});
      cnt = 0;
      for (k = 0; k < (1 << i) + 3; k++) begin
        pulses(0, 1, 4);
        #1;
        if (nco_out === ~pol)
          cnt++;
      end
      chk(33'(cnt), 33'(1 << i));
    end
    // A second reset in mid-run, with the oscillator still running.
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({29'h0, nco_out, pin_out, pin_out_en, overflow_irq_flag}, 33'h0);
    for (i = 0; i < 10; i++)
      rd(8'(4 * i), 8'h00);
    test_done();
  end
endmodule
